// [include/sar_seq_pkg.sv]
// Purpose: shared constants and types for the converter control sequencer
// Assumes: one clock, clk_sys at 10 MHz; conversion cycles counted on conv_clock edges
// Notes: all counts are in conversion clock periods
package sar_seq_pkg;
  // ==========================================================
  // timing counts in conversion clock periods
  localparam int CAL_PERIODS = 1399;
  localparam int ZERO_PERIODS = 26;
  localparam int ACQ_PERIODS = 7;
  localparam int ACQ_WR_PERIODS = 6;
  localparam int OFFSET_PERIODS = 64;
  localparam int MAG_BITS = 12;
  // ==========================================================
  // byte layout
  localparam int HI_NIBBLE_LSB = 8;
  localparam logic [7:0] TEST_LANES = 8'h6c;
  localparam logic [7:0] TEST_PATTERN = 8'h24;
  localparam logic [12:0] RESULT_RESET = 13'h0000;
  localparam logic [15:0] CORR_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CAL, ST_ZERO, ST_ACQ_TIMED, ST_ACQ_HOST, ST_CONVERT
  } seq_state_t;

  // host side strobes, all active low
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic sample_hold_n;
    logic calibrate_n;
    logic zero_offset_n;
  } host_ctl_t;

  // data bus pins
  typedef struct packed {
    logic [7:0] data_out;
    logic [7:0] data_oe;
  } data_pins_t;
endpackage

// [design/conv_clock_tick.sv]
// Purpose: one-cycle pulse on each rising edge of the conversion clock
// Assumes: conv_clock synchronous to clk_sys and slower than half its rate
// Notes: every sequencer count advances on this pulse
`timescale 1ns/1ps
module conv_clock_tick (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // conversion clock
  input wire logic conv_clock,
  output logic tick
);
  logic last;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // starts high so a clock already high at release is not taken as an edge
      last <= 1'b1;
    end else begin
      last <= conv_clock;
    end
  end

  assign tick = conv_clock & ~last;
endmodule

// [design/sar_register.sv]
// Purpose: successive approximation register, sign first then magnitude
// Assumes: comparator answers arrive one per step
// Notes: step 0 is the sign decision against analog ground
`timescale 1ns/1ps
module sar_register
  import sar_seq_pkg::*;
#(
  parameter int BITS = MAG_BITS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic step,
  input wire logic comp_high,
  // results
  output logic [BITS-1:0] trial,
  output logic sign,
  output logic done
);
  logic [BITS:0] cursor;

  always_ff @(posedge clk_sys) begin
    if (rst || clear) begin
      cursor <= {1'b1, {BITS{1'b0}}};
      trial <= '0;
      sign <= 1'b0;
      done <= 1'b0;
    end else if (step && !done) begin
      if (cursor[BITS]) begin
        // negative input sets the sign
        sign <= ~comp_high; // [R11]
        trial <= {1'b1, {(BITS-1){1'b0}}};
      end else begin
        // keep the trial bit when input exceeds the dac, try the next one
        trial <= (trial & ~cursor[BITS-1:0]) | (comp_high ? cursor[BITS-1:0] : '0)
          | (cursor[BITS-1:0] >> 1); // [R12]
        done <= cursor[0];
      end
      cursor <= cursor >> 1;
    end
  end
endmodule

// [design/sar_converter_control_sequencer.sv]
// Purpose: control sequencer of a self-calibrating 12-bit plus sign sar converter
// Assumes: host strobes synchronous to clk_sys; comparator and dac are analog neighbours
// Notes: data bus is split into out, enable; the pad ring resolves the wire
`timescale 1ns/1ps

// Overview of operation
// R01: calibrate low starts 1399-period calibration, eoc low
// R02: calibration measures offset, then dac mismatch, stores
// R03: chip select with write starts a conversion
// R04: zero offset low inserts 26-period zero cycle
// R05: host holds zero offset low whole sequence
// R06: after zero cycle, sample input seven periods
// R07: zero offset high: acquisition opens at eoc rise; code opens it at the write
// R08: eoc falls when acquisition window closes
// R09: chip select with sample/hold low opens window
// R10: sample/hold rising holds and starts conversion at once
// R11: first comparison decides sign against ground
// R12: magnitude bits trial-set from msb downward
// R13: latch result, then raise eoc
// R14: first read gives high byte, sign extended
// R15: second read gives low byte, lsb lowest
// R16: test mode drives data lines 2,3,5,6
// R17: every conversion start resets sequencing state
// R18: host avoids starts during sampling or eoc low
// R19: without zero cycle restart only after eoc high
// R20: zero cycle restart early window or after eoc
// R21: calibration ignores starts and resets until done
// R22: power-up calibration runs automatically
// R23: completion low on result, high on read/start
// R24: host holds calibrate high before conversions
// R25: write-started acquisition ends six periods after write
// R26: data lines driven only on read or test
// R27: all counts come from the conversion clock
module sar_converter_control_sequencer
  import sar_seq_pkg::*;
#(
  parameter int CAL_COUNT = CAL_PERIODS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // conversion clock
  input wire logic conv_clock,
  // host controls
  input wire host_ctl_t host,
  // analog neighbours
  input wire logic comp_high,
  output logic [MAG_BITS-1:0] dac_code,
  output logic sampling,
  output logic cal_offset_phase,
  output logic cal_mismatch_phase,
  // status
  output logic end_of_conv,
  output logic conv_done_n,
  // data bus
  output data_pins_t data_pins
);
  // ==========================================================
  // conversion clock and edge detection
  seq_state_t state;
  logic tick;
  logic [10:0] count;
  host_ctl_t prev;
  logic wr_rise, sh_fall, sh_rise, cal_fall, rd_fall, start;
  logic zero_req;
  logic sar_clear, sar_done, sar_sign;
  logic [MAG_BITS-1:0] trial;
  logic [12:0] result;
  logic high_next;
  logic [15:0] corr_offset, corr_mismatch;
  logic test_mode, reading;

  conv_clock_tick u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .conv_clock(conv_clock),
    .tick(tick) // [R27]
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev <= '1;
    end else begin
      prev <= host;
    end
  end

  assign wr_rise = ~host.cs_n & host.wr_n & ~prev.wr_n; // [R03]
  assign sh_fall = ~host.cs_n & ~host.sample_hold_n & prev.sample_hold_n; // [R09]
  assign sh_rise = host.sample_hold_n & ~prev.sample_hold_n;
  assign cal_fall = host.cs_n & host.sample_hold_n & ~host.calibrate_n & prev.calibrate_n;
  assign rd_fall = ~host.cs_n & ~host.rd_n & (prev.rd_n | prev.cs_n);
  // calibration cannot be interrupted
  assign start = (wr_rise | sh_fall) & (state != ST_CAL); // [R21]

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // power-up calibration
      state <= ST_CAL; // [R22]
      count <= '0;
      zero_req <= 1'b0;
    end else if (cal_fall && state != ST_CAL) begin
      state <= ST_CAL; // [R01]
      count <= '0;
    end else if (start) begin
      // a start throws away whatever sequence was running
      count <= '0; // [R17]
      zero_req <= wr_rise & ~host.zero_offset_n;
      if (sh_fall) begin
        state <= ST_ACQ_HOST;
      end else if (!host.zero_offset_n) begin
        state <= ST_ZERO; // [R04]
      end else begin
        state <= ST_ACQ_TIMED; // [R07]
      end
    end else begin
      unique case (state)
        ST_IDLE: begin
          count <= '0;
        end
        ST_CAL: begin
          if (tick) begin
            if (count == 11'(CAL_COUNT - 1)) begin
              state <= ST_IDLE; // [R01]
              count <= '0;
            end else begin
              count <= count + 11'd1;
            end
          end
        end
        ST_ZERO: begin
          if (tick) begin
            if (count == 11'(ZERO_PERIODS - 1)) begin
              state <= ST_ACQ_TIMED; // [R06]
              count <= '0;
            end else begin
              count <= count + 11'd1;
            end
          end
        end
        ST_ACQ_TIMED: begin
          if (tick) begin
            // window is seven periods after a zero cycle, six after a plain write
            if (count == 11'((zero_req ? ACQ_PERIODS : ACQ_WR_PERIODS) - 1)) begin
              state <= ST_CONVERT; // [R25]
              count <= '0;
            end else begin
              count <= count + 11'd1;
            end
          end
        end
        ST_ACQ_HOST: begin
          if (sh_rise) begin
            state <= ST_CONVERT; // [R10]
          end
        end
        ST_CONVERT: begin
          if (sar_done) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // calibration phases and correction storage
  assign cal_offset_phase = (state == ST_CAL) && (count < 11'(OFFSET_PERIODS));
  assign cal_mismatch_phase = (state == ST_CAL) && (count >= 11'(OFFSET_PERIODS));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      corr_offset <= CORR_RESET;
    end else if (cal_offset_phase && tick) begin
      // offset first, accumulated comparator answers
      corr_offset <= corr_offset + {15'h0000, comp_high}; // [R02]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      corr_mismatch <= CORR_RESET;
    end else if (cal_mismatch_phase && tick) begin
      corr_mismatch <= corr_mismatch + {15'h0000, comp_high}; // [R02]
    end
  end

  // ==========================================================
  // approximation
  assign sar_clear = (state != ST_CONVERT);
  assign sampling = (state == ST_ACQ_TIMED) || (state == ST_ACQ_HOST);
  // correction word trims the dac code during trials
  assign dac_code = trial ^ corr_mismatch[MAG_BITS-1:0] ^ corr_offset[MAG_BITS-1:0];

  sar_register #(
    .BITS(MAG_BITS)
  ) u_sar (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(sar_clear),
    .step(tick),
    .comp_high(comp_high),
    .trial(trial),
    .sign(sar_sign),
    .done(sar_done)
  );

  // ==========================================================
  // result latch and status
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result <= RESULT_RESET;
    end else if (state == ST_CONVERT && sar_done) begin
      result <= {sar_sign, trial}; // [R13]
    end
  end

  // eoc is low through calibration, zero cycle and conversion
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      end_of_conv <= 1'b0;
    end else begin
      end_of_conv <= (state == ST_IDLE) || sampling; // [R08]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conv_done_n <= 1'b1;
    end else if (state == ST_CONVERT && sar_done) begin
      conv_done_n <= 1'b0; // [R23]
    end else if (rd_fall || start || cal_fall) begin
      conv_done_n <= 1'b1; // [R23]
    end
  end

  // byte pointer: the first read after a result is the high byte
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      high_next <= 1'b1;
    end else if (state == ST_CONVERT && sar_done) begin
      high_next <= 1'b1;
    end else if (!prev.cs_n && !prev.rd_n && !reading) begin
      // advance at the end of a read so the byte holds while the host reads it
      high_next <= ~high_next; // [R14] [R15]
    end
  end

  // ==========================================================
  // data bus
  assign reading = ~host.cs_n & ~host.rd_n;
  assign test_mode = ~host.cs_n & host.rd_n & host.sample_hold_n & ~host.calibrate_n;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_pins <= '0;
    end else if (test_mode) begin
      // factory test lanes only; the host must keep clear of this combination
      data_pins.data_out <= TEST_PATTERN; // [R16]
      data_pins.data_oe <= TEST_LANES; // [R16]
    end else if (reading) begin
      data_pins.data_oe <= 8'hff; // [R26]
      if (high_next) begin
        data_pins.data_out <= {{4{result[12]}}, result[11:HI_NIBBLE_LSB]}; // [R14]
      end else begin
        data_pins.data_out <= result[7:0]; // [R15]
      end
    end else begin
      data_pins.data_oe <= 8'h00; // [R26]
      data_pins.data_out <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  sequence s_cal_begin;
    cal_fall && state != ST_CAL;
  endsequence

  a_cal_eoc_low: assert property (@(posedge clk_sys) disable iff (rst)
    s_cal_begin |=> ##1 !end_of_conv) else $error("eoc not low in calibration"); // [R01]
  a_cal_no_start: assert property (@(posedge clk_sys) disable iff (rst)
    state == ST_CAL && !cal_fall && (wr_rise || sh_fall) && !(tick && count == 11'(CAL_COUNT - 1))
    |=> state == ST_CAL)
    else $error("start broke calibration"); // [R21]
  a_zero_entry: assert property (@(posedge clk_sys) disable iff (rst)
    state != ST_CAL && wr_rise && !host.zero_offset_n && !cal_fall |=> state == ST_ZERO)
    else $error("zero cycle missing"); // [R04]
  a_sh_hold: assert property (@(posedge clk_sys) disable iff (rst)
    state == ST_ACQ_HOST && sh_rise && !start && !cal_fall |=> state == ST_CONVERT)
    else $error("hold not immediate"); // [R10]
  a_sign_order: assert property (@(posedge clk_sys) disable iff (rst)
    state == ST_CONVERT && sar_done |=> result[12] == $past(sar_sign) && result[11:0] == $past(trial)
    && !conv_done_n)
    else $error("result not latched"); // [R13]
  a_done_clear: assert property (@(posedge clk_sys) disable iff (rst)
    rd_fall && !(state == ST_CONVERT && sar_done) |=> conv_done_n)
    else $error("completion not cleared"); // [R23]
  a_bus_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !reading && !test_mode |=> data_pins.data_oe == 8'h00)
    else $error("bus driven when idle"); // [R26]
  a_test_lanes: assert property (@(posedge clk_sys) disable iff (rst)
    test_mode |=> data_pins.data_oe == 8'h6c) else $error("test lanes wrong"); // [R16]
  a_high_byte: assert property (@(posedge clk_sys) disable iff (rst)
    reading && !test_mode && high_next |=> data_pins.data_out[7:4] == {4{result[12]}})
    else $error("sign not extended"); // [R14]
endmodule

// [bench/comparator_model.sv]
// Purpose: comparator partner seen by the sequencer, driven by a full-scale input
// Assumes: full_pos high means a positive full-scale input, low a negative one
// Notes: a full-scale input lies beyond every dac level, so one answer fits each step
`timescale 1ns/1ps
module comparator_model (
  // stimulus
  input wire logic full_pos,
  input wire logic sampling,
  // answer
  output logic comp_high
);
  // ==========================================================
  // answer
  // while tracking the answer is meaningless, so it is inverted to expose early use
  assign comp_high = sampling ? ~full_pos : full_pos;
endmodule

// [bench/tb_sar_converter_control_sequencer.sv]
// Purpose: self-checking bench for the converter control sequencer
// Assumes: conv_clock at a quarter of clk_sys; short calibration count
// Notes: counts are in conv_clock ticks seen by the bench, with up to three ticks of slack
`timescale 1ns/1ps
module tb_sar_converter_control_sequencer;
  import sar_seq_pkg::*;
  localparam int CAL_N = 100;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic conv_clock = 1'b0;
  host_ctl_t host = 6'h3f;
  logic full_pos = 1'b1;
  logic comp_high;
  logic [MAG_BITS-1:0] dac_code;
  logic sampling, cal_offset_phase, cal_mismatch_phase, end_of_conv, conv_done_n;
  data_pins_t data_pins;
  int err_total = 0;
  int n_checks = 0;
  int t, t2;
  logic [7:0] b;

  always #50 clk_sys = ~clk_sys;
  always #200 conv_clock = ~conv_clock;

  sar_converter_control_sequencer #(.CAL_COUNT(CAL_N)) DUT (.clk_sys(clk_sys), .rst(rst),
    .conv_clock(conv_clock), .host(host), .comp_high(comp_high), .dac_code(dac_code),
    .sampling(sampling), .cal_offset_phase(cal_offset_phase), .cal_mismatch_phase(cal_mismatch_phase),
    .end_of_conv(end_of_conv), .conv_done_n(conv_done_n), .data_pins(data_pins));
  comparator_model CMP (.full_pos(full_pos), .sampling(sampling), .comp_high(comp_high));

  // ==========================================================
  // helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask

  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_rng(input int got, input int lo, input int hi, input string what);
    n_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("BAD t=%0t %s count %0d not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return end_of_conv;
      1: return conv_done_n;
      2: return sampling;
      default: return cal_offset_phase;
    endcase
  endfunction

  // waits for a level, counting conversion clock ticks on the way
  task automatic wait_lvl(input int w, input logic lvl, output int ticks);
    logic prev;
    int k;
    prev = conv_clock;
    ticks = 0;
    k = 0;
    while (pick(w) !== lvl && k < 3000) begin
      cyc(1);
      if (conv_clock && !prev) ticks++;
      prev = conv_clock;
      k++;
    end
    if (k >= 3000) begin
      err_total++;
      $display("BAD t=%0t wait on signal %0d ran out", $time, w);
      print_verdict();
    end
  endtask

  function automatic logic [7:0] exp_byte(input logic pos, input logic hi);
    if (hi) return pos ? 8'h0f : 8'hf0;
    return pos ? 8'hff : 8'h00;
  endfunction

  task automatic read_byte(output logic [7:0] v);
    host.cs_n = 1'b0;
    host.rd_n = 1'b0;
    cyc(2);
    v = data_pins.data_out;
    check_eq(data_pins.data_oe, 8'hff, "oe on read");
    host.rd_n = 1'b1;
    host.cs_n = 1'b1;
    cyc(2);
    check_eq(data_pins.data_oe, 8'h00, "oe idle");
  endtask

  // ==========================================================
  // scenarios
  task automatic calibrate();
    host.calibrate_n = 1'b0;
    cyc(3);
    check_eq({end_of_conv, conv_done_n, cal_offset_phase}, 3'b011, "cal start");
    host.calibrate_n = 1'b1;
    host.cs_n = 1'b0;
    host.wr_n = 1'b0;
    cyc(1);
    host.wr_n = 1'b1;
    cyc(1);
    host.cs_n = 1'b1;
    wait_lvl(3, 1'b0, t);
    check_rng(t, OFFSET_PERIODS - 3, OFFSET_PERIODS, "offset phase");
    check_eq(cal_mismatch_phase, 1'b1, "mismatch phase");
    wait_lvl(0, 1'b1, t2);
    check_rng(t + t2, CAL_N - 3, CAL_N + 1, "calibration");
    $display("calibration done");
  endtask

  // mode 0 write, 1 write with zero cycle, 2 sample/hold
  task automatic convert(input int mode, input logic pos);
    full_pos = pos;
    host.zero_offset_n = (mode != 1);
    host.cs_n = 1'b0;
    if (mode == 2) begin
      host.sample_hold_n = 1'b0;
      cyc(3);
      check_eq(sampling, 1'b1, "sh window");
      cyc(2 + $urandom_range(8));
      host.sample_hold_n = 1'b1;
      cyc(2);
      check_eq({sampling, end_of_conv}, 2'b00, "sh hold");
      host.cs_n = 1'b1;
    end else begin
      host.wr_n = 1'b0;
      cyc(1);
      host.wr_n = 1'b1;
      cyc(1);
      host.cs_n = 1'b1;
      if (mode == 1) begin
        wait_lvl(2, 1'b1, t);
        check_rng(t, ZERO_PERIODS - 2, ZERO_PERIODS + 1, "zero cycle");
        wait_lvl(2, 1'b0, t);
        check_rng(t, ACQ_PERIODS - 1, ACQ_PERIODS + 1, "acquisition");
        // eoc is registered, one cycle behind the window
        cyc(1);
        check_eq(end_of_conv, 1'b0, "eoc at close");
      end else begin
        wait_lvl(0, 1'b0, t);
        check_rng(t, ACQ_WR_PERIODS - 1, ACQ_PERIODS, "timed window");
      end
    end
    wait_lvl(1, 1'b0, t);
    check_rng(t, MAG_BITS, MAG_BITS + 2, "approximation");
    cyc(2);
    // the next start is issued only after eoc is back high
    check_eq(end_of_conv, 1'b1, "eoc rise");
    read_byte(b);
    check_eq(b, exp_byte(pos, 1'b1), "high byte");
    check_eq(conv_done_n, 1'b1, "done cleared");
    read_byte(b);
    check_eq(b, exp_byte(pos, 1'b0), "low byte");
    host.zero_offset_n = 1'b1;
    $display("conversion mode %0d done", mode);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h196b1591));
    cyc(3);
    check_eq({end_of_conv, conv_done_n, data_pins.data_oe}, 10'h100, "in reset");
    check_eq(dac_code, 12'h000, "dac in reset");
    rst = 1'b0;
    wait_lvl(0, 1'b1, t);
    check_rng(t, CAL_N - 1, CAL_N + 1, "power-up cal");
    $display("power-up done");
    calibrate();
    host.cs_n = 1'b0;
    cyc(1);
    host.calibrate_n = 1'b0;
    cyc(2);
    check_eq(data_pins.data_oe, {8'h00, TEST_LANES}, "test lanes");
    check_eq(data_pins.data_out & TEST_LANES, {8'h00, TEST_PATTERN}, "test pattern");
    host.calibrate_n = 1'b1;
    cyc(1);
    host.cs_n = 1'b1;
    cyc(2);
    check_eq({end_of_conv, data_pins.data_oe}, 9'h100, "test exit");
    $display("test mode done");
    for (int m = 0; m < 3; m++) begin
      convert(m, 1'b1);
      convert(m, 1'b0);
    end
    repeat (6) convert($urandom_range(2), $urandom_range(1));
    print_verdict();
  end
endmodule
